// ===== fmsp_defines.svh
`ifndef FMSP_DEFINES_SVH
`define FMSP_DEFINES_SVH
`define FMSP_ADDR_PWR 8'h87
`define FMSP_ADDR_BAUD 8'h8f
`define FMSP_ADDR_CTRL 8'h98
`define FMSP_ADDR_BUF 8'h99
`define FMSP_CTRL_HI_ERR 7
`define FMSP_CTRL_LO 6
`define FMSP_CTRL_MP 5
`define FMSP_CTRL_REN 4
`define FMSP_CTRL_TX9 3
`define FMSP_CTRL_RX9 2
`define FMSP_CTRL_TXDONE 1
`define FMSP_CTRL_RXDONE 0
`define FMSP_PWR_DOUBLE 7
`define FMSP_PWR_FESEL 6
`define FMSP_BAUD_T2 0
`define FMSP_BAUD_M0FAST 1
`define FMSP_CTRL_RST 8'h00
`define FMSP_PWR_RST 8'h00
`define FMSP_BAUD_RST 8'h00
`define FMSP_BUF_RST 8'h00
`define FMSP_M0_DIV_SLOW 4'hc
`define FMSP_M0_DIV_FAST 4'h6
`define FMSP_M2_TERM_SLOW 2'h3
`define FMSP_M2_TERM_FAST 2'h1
`define FMSP_T1_TERM_SLOW 2'h1
`define FMSP_T1_TERM_FAST 2'h0
`define FMSP_T2_TERM 2'h0
`define FMSP_CNT_LAST 4'hf
`define FMSP_SAMP_A 4'h7
`define FMSP_SAMP_B 4'h8
`define FMSP_SAMP_C 4'h9
`define FMSP_RX_LOAD 9'h1ff
`define FMSP_M0_RX_LOAD 8'hfe
`define FMSP_TX_END 8'h01
`endif

// ===== fmsp_pkg.sv
package fmsp_pkg;
  typedef enum logic [1:0] {FMSP_M_SHIFT = 2'h0, FMSP_M_UART8 = 2'h1,
    FMSP_M_FIX9 = 2'h2, FMSP_M_VAR9 = 2'h3} fmsp_mode_t;
  typedef enum logic [2:0] {FMSP_TX_IDLE = 3'h1, FMSP_TX_START = 3'h2,
    FMSP_TX_DATA = 3'h4} fmsp_tx_state_t;
endpackage

// ===== fmsp_serial_port.sv
// Contract
// - four modes chosen by two mode bits
// - mode 0 data on rxd, clock on txd
// - mode 0 rate clock/12, or clock/6
// - write loads data plus marker, send follows
// - shift right on fall, end sets tx flag
// - mode 0 receive loads 11111110 then active
// - sample on rise, zero at top ends
// - mode 1 frame start, eight bits, stop
// - mode 1 rate from timer overflows
// - async transmit starts at counter rollover
// - start, data, shifts; done at tenth rollover
// - sixteen x sampling, edge resets counter, load
// - majority of samples seven, eight, nine
// - nonzero start bit restarts edge hunt
// - mode 1 store gated by flag, stop
// - mode 2 frame with programmable ninth bit
// - mode 2 rate clock/64 or /32
// - ninth bit loaded, stop inserted, eleventh rollover
// - modes 2/3 store gated by ninth bit
// - mode 3 like mode 2, timer rate
// - async reception only while receive enabled
// - missing stop sets shared frame error flag
// - one address, separate tx and rx buffers
`include "fmsp_defines.svh"
`timescale 1ns/10ps
module fmsp_serial_port
  import fmsp_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic RXD_IN,
  output logic RXD_OUT,
  output logic RXD_OE_N,
  output logic TXD_OUT,
  input wire logic TIMER1_OVF,
  input wire logic TIMER2_OVF
);
  logic mode_bit_hi_reg, mode_bit_lo_reg, multiproc_enable_reg, rx_enable_reg;
  logic tx_ninth_bit_reg, rx_ninth_bit_reg, tx_done_flag_reg, rx_done_flag_reg;
  logic frame_err_flag_reg, baud_double_reg, frame_err_select_reg;
  logic timer2_sel_reg, m0_fast_reg;
  logic [7:0] rx_buf_reg, rdata_reg;
  logic rxd_meta_reg, rxd_sync_reg, rxd_prev_reg;
  logic [1:0] pre_cnt_reg, pre_term;
  logic tick_reg, src_pulse;
  logic [3:0] tx_cnt_reg, m0_cnt_reg, m0_div, m0_half;
  fmsp_tx_state_t tx_state_reg;
  logic [8:0] tx_shift_reg;
  logic tx_req_reg, tx_first_reg, tx_shift_ev, tx_done_set, tx_roll;
  logic m0_active, m0_fall, m0_rise, m0_sclk;
  logic [7:0] m0_rx_shift_reg, m0_rx_data;
  logic m0_rx_pend_reg, m0_rx_busy_reg, m0_rx_start, m0_rx_end;
  logic rx_busy_reg, rx_first_reg, samp_a_reg, samp_b_reg;
  logic [3:0] rx_cnt_reg;
  logic [9:0] rx_shift_reg;
  logic rx_start, bit_ev, vote, rx_end, rx_accept, rx_store, ninth;
  logic [7:0] rx_data;
  logic txd_next, wr_ctrl, wr_buf, is_m0, is_m1;
  fmsp_mode_t mode;

  assign mode = fmsp_mode_t'({mode_bit_hi_reg, mode_bit_lo_reg});
  assign is_m0 = (mode == FMSP_M_SHIFT);
  assign is_m1 = (mode == FMSP_M_UART8);
  assign wr_ctrl = WR && (ADDR == `FMSP_ADDR_CTRL);
  assign wr_buf = WR && (ADDR == `FMSP_ADDR_BUF);

  // pin synchroniser
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
      rxd_prev_reg <= 1'b1;
    end
    else
    begin
      rxd_meta_reg <= RXD_IN;
      rxd_sync_reg <= rxd_meta_reg;
      rxd_prev_reg <= rxd_sync_reg;
    end
  end

  always_comb
  begin
    src_pulse = timer2_sel_reg ? TIMER2_OVF : TIMER1_OVF;
    pre_term = timer2_sel_reg ? `FMSP_T2_TERM :
      (baud_double_reg ? `FMSP_T1_TERM_FAST : `FMSP_T1_TERM_SLOW);
    if (mode == FMSP_M_FIX9)
    begin
      src_pulse = 1'b1;
      pre_term = baud_double_reg ? `FMSP_M2_TERM_FAST : `FMSP_M2_TERM_SLOW;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      pre_cnt_reg <= 2'h0;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= 1'b0;
      if (src_pulse)
      begin
        if (pre_cnt_reg >= pre_term)
        begin
          pre_cnt_reg <= 2'h0;
          tick_reg <= 1'b1;
        end
        else
          pre_cnt_reg <= pre_cnt_reg + 2'h1;
      end
    end
  end

  // transmit divide-by-16
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      tx_cnt_reg <= 4'h0;
    else if (tick_reg)
      tx_cnt_reg <= tx_cnt_reg + 4'h1;
  end
  assign tx_roll = tick_reg && (tx_cnt_reg == `FMSP_CNT_LAST);

  assign m0_div = m0_fast_reg ? `FMSP_M0_DIV_FAST : `FMSP_M0_DIV_SLOW;
  assign m0_half = m0_div >> 1;
  assign m0_active = (is_m0 && tx_state_reg == FMSP_TX_DATA) || m0_rx_busy_reg;
  assign m0_fall = m0_active && (m0_cnt_reg == m0_div - 4'h1);
  assign m0_rise = m0_active && (m0_cnt_reg == m0_half - 4'h1);
  assign m0_sclk = (m0_cnt_reg >= m0_half);

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      m0_cnt_reg <= 4'h0;
    else if (m0_rx_pend_reg || (is_m0 && tx_state_reg == FMSP_TX_IDLE && tx_req_reg))
      m0_cnt_reg <= 4'h0;
    else if (m0_fall)
      m0_cnt_reg <= 4'h0;
    else if (m0_active)
      m0_cnt_reg <= m0_cnt_reg + 4'h1;
  end

  // shift events and end of transmit
  assign tx_shift_ev = (tx_state_reg == FMSP_TX_DATA) && (is_m0 ? m0_fall : tx_roll);
  assign tx_done_set = tx_shift_ev && (tx_shift_reg[8:1] == `FMSP_TX_END);

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      tx_state_reg <= FMSP_TX_IDLE;
      tx_shift_reg <= 9'h1ff;
      tx_req_reg <= 1'b0;
      tx_first_reg <= 1'b0;
    end
    else
    begin
      case (tx_state_reg)
        FMSP_TX_IDLE:
          // wait for rollover in async modes
          if (tx_req_reg && (is_m0 || tx_roll))
          begin
            tx_req_reg <= 1'b0;
            tx_state_reg <= is_m0 ? FMSP_TX_DATA : FMSP_TX_START;
          end
        FMSP_TX_START:
          if (tx_roll)
          begin
            tx_state_reg <= FMSP_TX_DATA;
            tx_first_reg <= 1'b1;
          end
        FMSP_TX_DATA:
          if (tx_shift_ev)
          begin
            // first shift inserts stop in 9-bit modes
            tx_shift_reg <= {(!is_m0 && mode_bit_hi_reg && tx_first_reg), tx_shift_reg[8:1]};
            tx_first_reg <= 1'b0;
            if (tx_done_set)
              tx_state_reg <= FMSP_TX_IDLE;
          end
        default:
          tx_state_reg <= FMSP_TX_IDLE;
      endcase
      // load data with marker or ninth bit
      if (wr_buf)
      begin
        tx_shift_reg <= {(mode_bit_hi_reg ? tx_ninth_bit_reg : 1'b1), WDATA};
        tx_req_reg <= 1'b1;
      end
    end
  end

  assign m0_rx_start = is_m0 && rx_enable_reg && !rx_done_flag_reg && !m0_rx_pend_reg
    && !m0_rx_busy_reg && tx_state_reg == FMSP_TX_IDLE && !tx_req_reg;
  assign m0_rx_end = m0_rx_busy_reg && m0_rise && !m0_rx_shift_reg[7];

  // first bit in lands as bit 0
  always_comb
  begin
    m0_rx_data = 8'h00;
    for (int i = 0; i < 8; i++)
      m0_rx_data[i] = (i == 7) ? rxd_sync_reg : m0_rx_shift_reg[6 - i];
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      m0_rx_shift_reg <= 8'hff;
      m0_rx_pend_reg <= 1'b0;
      m0_rx_busy_reg <= 1'b0;
    end
    else if (m0_rx_start)
    begin
      m0_rx_shift_reg <= `FMSP_M0_RX_LOAD;
      m0_rx_pend_reg <= 1'b1;
    end
    else if (m0_rx_pend_reg)
    begin
      m0_rx_pend_reg <= 1'b0;
      m0_rx_busy_reg <= 1'b1;
    end
    else if (m0_rx_busy_reg && m0_rise)
    begin
      m0_rx_shift_reg <= {m0_rx_shift_reg[6:0], rxd_sync_reg};
      if (!m0_rx_shift_reg[7])
        m0_rx_busy_reg <= 1'b0;
    end
  end

  // start edge only with receive enabled
  assign rx_start = !is_m0 && rx_enable_reg && !rx_busy_reg && rxd_prev_reg && !rxd_sync_reg;
  assign bit_ev = rx_busy_reg && tick_reg && (rx_cnt_reg == `FMSP_SAMP_C);
  assign vote = (samp_a_reg & samp_b_reg) | (samp_a_reg & rxd_sync_reg)
    | (samp_b_reg & rxd_sync_reg);
  // mode 1 ends at stop bit
  assign rx_end = bit_ev && !rx_first_reg && (is_m1 ? !rx_shift_reg[1] : !rx_shift_reg[0]);
  assign ninth = is_m1 ? vote : rx_shift_reg[9];
  assign rx_data = is_m1 ? rx_shift_reg[9:2] : rx_shift_reg[8:1];
  // store gate, mode 1 uses stop bit
  // store gate, modes 2/3 use ninth bit
  assign rx_accept = !rx_done_flag_reg && (!multiproc_enable_reg || ninth);
  assign rx_store = (rx_end && rx_accept) || m0_rx_end;

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      rx_busy_reg <= 1'b0;
      rx_first_reg <= 1'b0;
      rx_cnt_reg <= 4'h0;
      rx_shift_reg <= 10'h3ff;
      samp_a_reg <= 1'b1;
      samp_b_reg <= 1'b1;
    end
    // edge resets counter and loads ones
    else if (rx_start)
    begin
      rx_busy_reg <= 1'b1;
      rx_first_reg <= 1'b1;
      rx_cnt_reg <= 4'h0;
      rx_shift_reg <= {1'b1, `FMSP_RX_LOAD};
    end
    else if (rx_busy_reg && tick_reg)
    begin
      rx_cnt_reg <= rx_cnt_reg + 4'h1;
      if (rx_cnt_reg == `FMSP_SAMP_A)
        samp_a_reg <= rxd_sync_reg;
      if (rx_cnt_reg == `FMSP_SAMP_B)
        samp_b_reg <= rxd_sync_reg;
      if (bit_ev)
      begin
        rx_first_reg <= 1'b0;
        rx_shift_reg <= {vote, rx_shift_reg[9:1]};
        if ((rx_first_reg && vote) || rx_end)
          rx_busy_reg <= 1'b0;
      end
    end
  end

  // flags set by hardware, cleared by software write
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      {mode_bit_hi_reg, mode_bit_lo_reg, multiproc_enable_reg, rx_enable_reg,
        tx_ninth_bit_reg, rx_ninth_bit_reg, tx_done_flag_reg,
        rx_done_flag_reg} <= `FMSP_CTRL_RST;
      frame_err_flag_reg <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        if (!frame_err_select_reg)
          mode_bit_hi_reg <= WDATA[`FMSP_CTRL_HI_ERR];
        mode_bit_lo_reg <= WDATA[`FMSP_CTRL_LO];
        multiproc_enable_reg <= WDATA[`FMSP_CTRL_MP];
        rx_enable_reg <= WDATA[`FMSP_CTRL_REN];
        tx_ninth_bit_reg <= WDATA[`FMSP_CTRL_TX9];
      end
      if (rx_end && rx_accept)
        rx_ninth_bit_reg <= ninth;
      else if (wr_ctrl)
        rx_ninth_bit_reg <= WDATA[`FMSP_CTRL_RX9];
      if (tx_done_set)
        tx_done_flag_reg <= 1'b1;
      else if (wr_ctrl)
        tx_done_flag_reg <= WDATA[`FMSP_CTRL_TXDONE];
      if (rx_store)
        rx_done_flag_reg <= 1'b1;
      else if (wr_ctrl)
        rx_done_flag_reg <= WDATA[`FMSP_CTRL_RXDONE];
      if (rx_end && !vote)
        frame_err_flag_reg <= 1'b1;
      else if (wr_ctrl && frame_err_select_reg)
        frame_err_flag_reg <= WDATA[`FMSP_CTRL_HI_ERR];
    end
  end

  // power and baud option registers
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      {baud_double_reg, frame_err_select_reg} <= 2'(`FMSP_PWR_RST >> 6);
      {m0_fast_reg, timer2_sel_reg} <= 2'(`FMSP_BAUD_RST);
    end
    else
    begin
      if (WR && ADDR == `FMSP_ADDR_PWR)
      begin
        baud_double_reg <= WDATA[`FMSP_PWR_DOUBLE];
        frame_err_select_reg <= WDATA[`FMSP_PWR_FESEL];
      end
      if (WR && ADDR == `FMSP_ADDR_BAUD)
      begin
        timer2_sel_reg <= WDATA[`FMSP_BAUD_T2];
        m0_fast_reg <= WDATA[`FMSP_BAUD_M0FAST];
      end
    end
  end

  // receive buffer apart from transmit shifter
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      rx_buf_reg <= `FMSP_BUF_RST;
    else if (m0_rx_end)
      rx_buf_reg <= m0_rx_data;
    else if (rx_end && rx_accept)
      rx_buf_reg <= rx_data;
  end

  // read port, one cycle latency
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      rdata_reg <= 8'h00;
    else if (!RD)
      rdata_reg <= 8'h00;
    else
      case (ADDR)
        `FMSP_ADDR_CTRL: rdata_reg <= {(frame_err_select_reg ? frame_err_flag_reg :
          mode_bit_hi_reg), mode_bit_lo_reg, multiproc_enable_reg, rx_enable_reg,
          tx_ninth_bit_reg, rx_ninth_bit_reg, tx_done_flag_reg, rx_done_flag_reg};
        `FMSP_ADDR_BUF: rdata_reg <= rx_buf_reg;
        `FMSP_ADDR_PWR: rdata_reg <= {baud_double_reg, frame_err_select_reg, 6'h00};
        `FMSP_ADDR_BAUD: rdata_reg <= {6'h00, m0_fast_reg, timer2_sel_reg};
        default: rdata_reg <= 8'h00;
      endcase
  end
  assign RDATA = rdata_reg;

  always_comb
  begin
    txd_next = 1'b1;
    if (is_m0)
      txd_next = m0_active ? m0_sclk : 1'b1;
    else if (tx_state_reg == FMSP_TX_START)
      txd_next = 1'b0;
    else if (tx_state_reg == FMSP_TX_DATA)
      txd_next = tx_shift_reg[0];
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      TXD_OUT <= 1'b1;
      RXD_OUT <= 1'b1;
      RXD_OE_N <= 1'b1;
    end
    else
    begin
      TXD_OUT <= txd_next;
      RXD_OUT <= tx_shift_reg[0];
      RXD_OE_N <= !(is_m0 && tx_state_reg == FMSP_TX_DATA);
    end
  end

  a_send_after_wr: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    wr_buf && is_m0 && tx_state_reg == FMSP_TX_IDLE |=> ##1 tx_state_reg == FMSP_TX_DATA)
    else $error("mode 0 send late");
  a_m0_fall_gap: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    m0_fall |=> !m0_fall [*5])
    else $error("shift clock too fast");
  a_tx_end_flag: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    tx_state_reg == FMSP_TX_DATA ##1 tx_state_reg == FMSP_TX_IDLE |-> tx_done_flag_reg)
    else $error("transmit ended without flag");
  a_rx_edge_load: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    rx_start |=> rx_cnt_reg == 4'h0 && rx_shift_reg == 10'h3ff && rx_busy_reg)
    else $error("start edge load wrong");
  a_false_start: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    bit_ev && rx_first_reg && vote |=> !rx_busy_reg)
    else $error("false start accepted");
  a_drop_frame: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    rx_end && !rx_accept |=> $stable(rx_buf_reg))
    else $error("gated frame stored");
  a_m0_rx_seq: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    m0_rx_start |=> m0_rx_pend_reg && m0_rx_shift_reg == 8'hfe ##1 m0_rx_busy_reg)
    else $error("mode 0 receive start wrong");
  a_fe_sticky: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    frame_err_flag_reg && !(wr_ctrl && frame_err_select_reg) |=> frame_err_flag_reg)
    else $error("frame error lost");
  a_buf_read: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    RD && ADDR == `FMSP_ADDR_BUF |=> RDATA == $past(rx_buf_reg))
    else $error("buffer read wrong");
endmodule

// ===== fmsp_far_end.sv
`timescale 1ns/10ps
module fmsp_far_end
(
  input wire logic clk,
  input wire logic txd,
  input wire logic rxd_pin,
  input wire logic rxd_oe_n,
  input wire logic sync_mode,
  input wire logic [15:0] bit_clks,
  input wire logic [3:0] nbits,
  output logic far_rxd,
  output logic got_valid,
  output logic [10:0] got_frame
);
  logic [10:0] frame;
  logic [7:0] m0_data;
  logic [3:0] m0_cnt = 4'h0;
  logic txd_d = 1'b1;
  logic pin_d = 1'b1;
  initial
  begin
    far_rxd = 1'b1;
    got_valid = 1'b0;
    got_frame = 11'h000;
  end
  task automatic send_frame(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      far_rxd <= f[i];
      repeat (bit_clks) @(posedge clk);
    end
    far_rxd <= 1'b1;
  endtask
  // mode 0 bits out, changed after each rise
  task automatic m0_feed(input logic [7:0] d);
    far_rxd <= d[0];
    for (int i = 1; i < 9; i++)
    begin
      @(posedge txd);
      @(posedge clk);
      far_rxd <= (i < 8) ? d[i[2:0]] : 1'b1;
    end
  endtask
  // short low pulse, then idle
  task automatic glitch();
    far_rxd <= 1'b0;
    repeat (3) @(posedge clk);
    far_rxd <= 1'b1;
    repeat (bit_clks * 2) @(posedge clk);
  endtask
  always @(negedge txd)
  begin
    if (!sync_mode)
    begin
      frame = 11'h000;
      repeat (bit_clks / 2) @(posedge clk);
      for (int i = 0; i < nbits; i++)
      begin
        frame[i] = txd;
        if (i < nbits - 1) repeat (bit_clks) @(posedge clk);
      end
      got_frame <= frame;
      got_valid <= 1'b1;
      @(posedge clk);
      got_valid <= 1'b0;
    end
  end
  // shift register peripheral, takes data at clock rise
  always @(posedge clk)
  begin
    txd_d <= txd;
    pin_d <= rxd_pin;
    if (sync_mode) got_valid <= 1'b0;
    if (rxd_oe_n) m0_cnt <= 4'h0;
    else if (sync_mode && !txd_d && txd && m0_cnt < 4'h8)
    begin
      m0_data[m0_cnt[2:0]] <= pin_d;
      m0_cnt <= m0_cnt + 4'h1;
      if (m0_cnt == 4'h7)
      begin
        got_frame <= {3'h0, pin_d, m0_data[6:0]};
        got_valid <= 1'b1;
      end
    end
  end
endmodule

// ===== fmsp_serial_port_test.sv
`timescale 1ns/10ps
`include "fmsp_defines.svh"
module fmsp_serial_port_test;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rxd_out;
  logic rxd_oe_n;
  logic txd_out;
  logic tovf = 1'b0;
  logic [1:0] tcnt = 2'h0;
  logic far_rxd;
  logic rxd_pin;
  logic sync_mode = 1'b0;
  logic [15:0] bit_clks = 16'd64;
  logic [3:0] nbits = 4'd11;
  logic got_valid;
  logic [10:0] got_frame;
  logic rd_seen = 1'b0;
  logic rd_watch = 1'b0;
  logic [10:0] fq[$];
  logic [7:0] rq[$];
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] b;
  logic [7:0] lb = 8'h00;
  logic n9;
  logic [1:0] md [4] = '{2'h2, 2'h2, 2'h1, 2'h3};
  logic [7:0] pw [4] = '{8'h00, 8'h80, 8'h00, 8'h00};
  logic [7:0] bo [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
  logic [15:0] bc [4] = '{16'd64, 16'd32, 16'd128, 16'd64};
  logic [3:0] nb [4] = '{4'd11, 4'd11, 4'd10, 4'd11};

  assign rxd_pin = rxd_oe_n ? far_rxd : rxd_out;
  always #50 sys_clk = ~sys_clk;

  fmsp_serial_port i_dut
  (
    .SYS_CLK(sys_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .RXD_IN(rxd_pin), .RXD_OUT(rxd_out), .RXD_OE_N(rxd_oe_n),
    .TXD_OUT(txd_out), .TIMER1_OVF(tovf), .TIMER2_OVF(tovf)
  );
  fmsp_far_end i_far
  (
    .clk(sys_clk), .txd(txd_out), .rxd_pin(rxd_pin), .rxd_oe_n(rxd_oe_n),
    .sync_mode(sync_mode), .bit_clks(bit_clks), .nbits(nbits), .far_rxd(far_rxd),
    .got_valid(got_valid), .got_frame(got_frame)
  );

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string nm, input logic [10:0] seen, input logic [10:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s exp=%h seen=%h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    rd_watch = 1'b1;
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
    rd_watch = 1'b0;
  endtask
  task automatic wait_q();
    repeat (4000)
      if (fq.size() != 0) @(posedge sys_clk);
    if (fq.size() != 0) check("frame count", 11'h001, 11'h000);
    repeat (20) @(posedge sys_clk);
  endtask
  task automatic rx_case(input logic [7:0] c, input logic [10:0] f, input logic [7:0] ec,
    input logic [7:0] eb, input bit gl);
    wr_reg(`FMSP_ADDR_CTRL, c);
    if (gl) i_far.glitch();
    i_far.send_frame(f, nbits);
    repeat (20) @(posedge sys_clk);
    chk_rd(`FMSP_ADDR_CTRL, ec);
    chk_rd(`FMSP_ADDR_BUF, eb);
    lb = eb;
    wr_reg(`FMSP_ADDR_CTRL, c);
  endtask

  always @(posedge sys_clk)
  begin
    tcnt <= tcnt + 2'h1;
    tovf <= (tcnt == 2'h3);
    rd_seen <= rd;
    cyc++;
    if (got_valid)
    begin
      if (fq.size() == 0) check("frame", got_frame, ~got_frame);
      else check("frame", got_frame, fq.pop_front());
    end
    if (cyc == 40000)
    begin
      err_count++;
      end_of_test();
    end
  end
  always @(negedge sys_clk)
    if (rd_seen && rd_watch) check("rdata", {3'h0, rdata}, {3'h0, rq.pop_front()});

  initial
  begin
    void'($urandom(11));
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    chk_rd(`FMSP_ADDR_CTRL, 8'h00);
    chk_rd(`FMSP_ADDR_PWR, 8'h00);
    chk_rd(`FMSP_ADDR_BAUD, 8'h00);
    chk_rd(8'h55, 8'h00);
    sync_mode <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(`FMSP_ADDR_BAUD, {6'h00, k[0], 1'b0});
      b = 8'($urandom());
      fq.push_back({3'h0, b});
      wr_reg(`FMSP_ADDR_BUF, b);
      wait_q();
      chk_rd(`FMSP_ADDR_CTRL, 8'h02);
      wr_reg(`FMSP_ADDR_CTRL, 8'h00);
    end
    b = 8'($urandom());
    wr_reg(`FMSP_ADDR_CTRL, 8'h10);
    i_far.m0_feed(b);
    chk_rd(`FMSP_ADDR_BUF, b);
    chk_rd(`FMSP_ADDR_CTRL, 8'h11);
    lb = b;
    wr_reg(`FMSP_ADDR_CTRL, 8'h00);
    sync_mode <= 1'b0;
    wr_reg(`FMSP_ADDR_BAUD, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      n9 = 1'($urandom());
      b = 8'($urandom());
      bit_clks <= bc[k];
      nbits <= nb[k];
      wr_reg(`FMSP_ADDR_PWR, pw[k]);
      wr_reg(`FMSP_ADDR_BAUD, bo[k]);
      wr_reg(`FMSP_ADDR_CTRL, {md[k], 2'b00, n9, 3'b000});
      fq.push_back(nb[k] == 4'd10 ? {2'b01, b, 1'b0} : {1'b1, n9, b, 1'b0});
      wr_reg(`FMSP_ADDR_BUF, b);
      wait_q();
      chk_rd(`FMSP_ADDR_CTRL, {md[k], 2'b00, n9, 3'b010});
      wr_reg(`FMSP_ADDR_CTRL, 8'h00);
    end
    wr_reg(`FMSP_ADDR_BAUD, 8'h00);
    bit_clks <= 16'd128;
    nbits <= 4'd10;
    b = 8'($urandom());
    rx_case(8'h40, {2'b01, b, 1'b0}, 8'h40, lb, 1'b0);
    rx_case(8'h70, {2'b01, b, 1'b0}, 8'h75, b, 1'b1);
    b = 8'($urandom());
    rx_case(8'h70, {2'b00, b, 1'b0}, 8'h70, lb, 1'b0);
    bit_clks <= 16'd64;
    nbits <= 4'd11;
    rx_case(8'hb0, {2'b10, b, 1'b0}, 8'hb0, lb, 1'b0);
    rx_case(8'hb0, {2'b11, b, 1'b0}, 8'hb5, b, 1'b0);
    wr_reg(`FMSP_ADDR_PWR, 8'h40);
    wr_reg(`FMSP_ADDR_CTRL, 8'h10);
    chk_rd(`FMSP_ADDR_CTRL, 8'h10);
    n9 = 1'($urandom());
    b = 8'($urandom());
    rx_case(8'h10, {1'b0, n9, b, 1'b0}, {5'b10010, n9, 2'b01}, b, 1'b0);
    chk_rd(`FMSP_ADDR_CTRL, 8'h10);
    wr_reg(`FMSP_ADDR_PWR, 8'h00);
    chk_rd(`FMSP_ADDR_CTRL, 8'h90);
    end_of_test();
  end
endmodule
